// *** design/mgs_sequencer.v ***
// Group state sequencer: one state number per motion group, driven by host commands,
// homing and motion results, and fault classes.
// Assumes commands arrive as one-cycle strobes from logic on sys_clk_i; fault and
// completion inputs are asynchronous pins and are synchronised here.
// Summary of operation
// - After reset every group holds state 0, the uninitialized state.
// - From state 0 only initialize and shutdown are taken; initialize moves the group to 42 and powers the motors.
// - From 42 only home search and shutdown are taken, and successful homing gives state 11.
// - Failed homing gives state 3 for a following error or state 6 for an end of run.
// - Home search is refused in state 12; the host must shut down then initialize.
// - The state number encodes both the present condition and the last transition cause.
// - A state query returns the current state number of the named group.
// - Inhibit, motor, encoder faults e-stop to state 7 and end of travel outside homing brakes to state 8, both unpowered.
// - A following error in a ready, moving or disabled state disables motion and gives the disabled state; in 42 it is ignored.
// - Motion resume in the disabled state returns the group to ready without rehoming.
// - With the extra-groups option off only the 6-axis hexapod group may be configured.
// - With the option on up to two single-axis groups more are allowed on an 8-axis controller.
`timescale 1ns/1ps
`include "mgs_consts.vh"
module mgs_sequencer #(
  parameter NGRP = 3,
  parameter [3:0] FITTED_AXES = 4'h8
)
(
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire cmd_valid_i,
  input wire [3:0] cmd_code_i,
  input wire [1:0] cmd_group_i,
  input wire [1:0] cfg_groups_i,
  input wire extra_groups_option_i,
  input wire [NGRP-1:0] home_done_i,
  input wire [NGRP-1:0] move_done_i,
  input wire [NGRP-1:0] fault_inhibit_i,
  input wire [NGRP-1:0] fault_motor_i,
  input wire [NGRP-1:0] fault_encoder_i,
  input wire [NGRP-1:0] fault_travel_i,
  input wire [NGRP-1:0] fault_follow_i,
  output reg rsp_valid_o,
  output reg [7:0] rsp_code_o,
  output reg [7:0] rsp_state_o,
  output reg [NGRP-1:0] motor_power_o,
  output reg [1:0] groups_enabled_o
);
  reg rst_s1_reg;
  reg rst_s2_reg;
  wire rst_n = rst_s2_reg;
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  // Asynchronous status pins pass two flops before use
  localparam NSYN = 7 * NGRP;
  reg [NSYN-1:0] syn1_reg;
  reg [NSYN-1:0] syn2_reg;
  always @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syn1_reg <= {NSYN{1'b0}};
      syn2_reg <= {NSYN{1'b0}};
    end
    else
    begin
      syn1_reg <= {home_done_i, move_done_i, fault_inhibit_i, fault_motor_i,
        fault_encoder_i, fault_travel_i, fault_follow_i};
      syn2_reg <= syn1_reg;
    end
  end
  wire [NGRP-1:0] s_follow = syn2_reg[NGRP-1:0];
  wire [NGRP-1:0] s_travel = syn2_reg[2*NGRP-1:NGRP];
  wire [NGRP-1:0] s_encoder = syn2_reg[3*NGRP-1:2*NGRP];
  wire [NGRP-1:0] s_motor = syn2_reg[4*NGRP-1:3*NGRP];
  wire [NGRP-1:0] s_inhibit = syn2_reg[5*NGRP-1:4*NGRP];
  wire [NGRP-1:0] s_move = syn2_reg[6*NGRP-1:5*NGRP];
  wire [NGRP-1:0] s_home = syn2_reg[7*NGRP-1:6*NGRP];

  reg [7:0] state_reg [0:NGRP-1];
  reg [7:0] state_next [0:NGRP-1];
  reg [1:0] groups_next;
  reg rsp_valid_next;
  reg [7:0] rsp_code_next;
  reg [7:0] rsp_state_next;
  reg [NGRP-1:0] power_next;
  reg [7:0] cur;
  reg sel;
  reg cfg_ok;
  integer g;
  integer k;
  reg [7:0] evt_state;
  reg evt_hit;
  wire [NGRP-1:0] s_major = s_inhibit | s_motor | s_encoder | s_travel;

  function is_ready;
    input [7:0] s;
    begin
      is_ready = (s == `MGS_ST_READY_HOME) || (s == `MGS_ST_READY_MOTION);
    end
  endfunction

  function powered;
    input [7:0] s;
    begin
      powered = !((s == `MGS_ST_UNINIT) || (s == `MGS_ST_FE_HOMING) ||
        (s == `MGS_ST_EOR_HOMING) || (s == `MGS_ST_EMSTOP) ||
        (s == `MGS_ST_EMBRAKE) || (s == `MGS_ST_KILLED));
    end
  endfunction

  always @*
  begin
    groups_next = groups_enabled_o;
    rsp_valid_next = 1'b0;
    rsp_code_next = `MGS_ERR_OK;
    rsp_state_next = 8'h00;
    cur = 8'h00;
    sel = 1'b0;
    cfg_ok = 1'b0;
    evt_state = 8'h00;
    evt_hit = 1'b0;
    power_next = {NGRP{1'b0}};
    for (g = 0; g < NGRP; g = g + 1)
    begin
      state_next[g] = state_reg[g];
      // Major faults act on powered groups only, so a held pin keeps the cause code
      if (powered(state_reg[g]) && (s_inhibit[g] || s_motor[g] || s_encoder[g]))
        state_next[g] = `MGS_ST_EMSTOP;
      else if (powered(state_reg[g]) && s_travel[g])
        state_next[g] = (state_reg[g] == `MGS_ST_HOMING) ? `MGS_ST_EOR_HOMING
          : `MGS_ST_EMBRAKE;
      else if (s_follow[g])
      begin
        if (state_reg[g] == `MGS_ST_HOMING)
          state_next[g] = `MGS_ST_FE_HOMING;
        else if (powered(state_reg[g]) && state_reg[g] != `MGS_ST_UNREF)
          state_next[g] = `MGS_ST_DISABLED;
      end
      else if (s_home[g] && state_reg[g] == `MGS_ST_HOMING)
        state_next[g] = `MGS_ST_READY_HOME;
      else if (s_move[g] && state_reg[g] == `MGS_ST_MOVING)
        state_next[g] = `MGS_ST_READY_MOTION;
      else if (cmd_valid_i && cmd_code_i == `MGS_CMD_SHUTDOWN_ALL)
        state_next[g] = `MGS_ST_KILLED;
    end
    if (cmd_valid_i)
    begin
      rsp_valid_next = 1'b1;
      sel = ({1'b0, cmd_group_i} < groups_enabled_o + 2'h1) &&
        (cmd_group_i < NGRP);
      if (sel)
      begin
        cur = state_reg[cmd_group_i];
        evt_state = state_next[cmd_group_i];
        // Major faults, and any event that changes the state, outrank a command for this group in the same cycle
        evt_hit = (evt_state != cur) || s_major[cmd_group_i];
      end
      case (cmd_code_i)
        `MGS_CMD_CONFIG:
        begin
          // Single-axis groups need the option and an 8-axis controller
          cfg_ok = (cfg_groups_i == 2'h0) || (extra_groups_option_i &&
            FITTED_AXES >= `MGS_FULL_AXES && cfg_groups_i < `MGS_MAX_GROUPS);
          if (cfg_ok)
            groups_next = cfg_groups_i;
          else
            rsp_code_next = `MGS_ERR_BAD_GROUP;
        end
        `MGS_CMD_SHUTDOWN_ALL:
          rsp_code_next = `MGS_ERR_OK;
        default:
        begin
          if (!sel)
            rsp_code_next = `MGS_ERR_BAD_GROUP;
          else
          begin
            case (cmd_code_i)
              `MGS_CMD_QUERY:
                rsp_state_next = cur;
              `MGS_CMD_INIT:
                if (cur == `MGS_ST_UNINIT || !powered(cur))
                  state_next[cmd_group_i] = `MGS_ST_UNREF;
                else
                  rsp_code_next = `MGS_ERR_BAD_STATE;
              `MGS_CMD_HOME:
                // Ready-from-motion cannot rehome directly
                if (cur == `MGS_ST_UNREF)
                  state_next[cmd_group_i] = `MGS_ST_HOMING;
                else
                  rsp_code_next = `MGS_ERR_BAD_STATE;
              `MGS_CMD_SHUTDOWN:
                state_next[cmd_group_i] = `MGS_ST_KILLED;
              `MGS_CMD_RESUME:
                if (cur == `MGS_ST_DISABLED)
                  state_next[cmd_group_i] = `MGS_ST_READY_MOTION;
                else
                  rsp_code_next = `MGS_ERR_BAD_STATE;
              `MGS_CMD_MOVE:
                if (is_ready(cur))
                  state_next[cmd_group_i] = `MGS_ST_MOVING;
                else
                  rsp_code_next = `MGS_ERR_BAD_STATE;
              default:
                rsp_code_next = `MGS_ERR_BAD_CMD;
            endcase
          end
          if (evt_hit && cmd_code_i != `MGS_CMD_QUERY && rsp_code_next == `MGS_ERR_OK)
            rsp_code_next = `MGS_ERR_BAD_STATE;
          // A refused command leaves the state to the fault and status logic
          if (rsp_code_next != `MGS_ERR_OK && sel)
            state_next[cmd_group_i] = evt_state;
          if (sel && cmd_code_i != `MGS_CMD_QUERY && rsp_code_next == `MGS_ERR_OK)
            rsp_state_next = state_next[cmd_group_i];
        end
      endcase
    end
    for (g = 0; g < NGRP; g = g + 1)
      power_next[g] = powered(state_next[g]);
  end

  always @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (k = 0; k < NGRP; k = k + 1)
        state_reg[k] <= `MGS_ST_UNINIT;
      rsp_valid_o <= 1'b0;
      rsp_code_o <= `MGS_ERR_OK;
      rsp_state_o <= 8'h00;
      motor_power_o <= {NGRP{1'b0}};
      groups_enabled_o <= 2'h0;
    end
    else
    begin
      for (k = 0; k < NGRP; k = k + 1)
        state_reg[k] <= state_next[k];
      rsp_valid_o <= rsp_valid_next;
      rsp_code_o <= rsp_code_next;
      rsp_state_o <= rsp_state_next;
      motor_power_o <= power_next;
      groups_enabled_o <= groups_next;
    end
  end
endmodule

// *** inc/mgs_consts.vh ***
// State codes, command codes, error codes and group limits for the group state sequencer.
// Assumes inclusion by the sequencer module only.
`ifndef MGS_CONSTS_VH
`define MGS_CONSTS_VH
`define MGS_ST_UNINIT 8'h00
`define MGS_ST_FE_HOMING 8'h03
`define MGS_ST_EOR_HOMING 8'h06
`define MGS_ST_READY_HOME 8'h0b
`define MGS_ST_READY_MOTION 8'h0c
`define MGS_ST_UNREF 8'h2a
`define MGS_ST_DISABLED 8'h14
`define MGS_ST_EMSTOP 8'h07
`define MGS_ST_EMBRAKE 8'h08
`define MGS_ST_HOMING 8'h2b
`define MGS_ST_MOVING 8'h2c
`define MGS_ST_KILLED 8'h0a
`define MGS_CMD_NONE 4'h0
`define MGS_CMD_INIT 4'h1
`define MGS_CMD_HOME 4'h2
`define MGS_CMD_SHUTDOWN 4'h3
`define MGS_CMD_SHUTDOWN_ALL 4'h4
`define MGS_CMD_RESUME 4'h5
`define MGS_CMD_QUERY 4'h6
`define MGS_CMD_MOVE 4'h7
`define MGS_CMD_CONFIG 4'h8
`define MGS_ERR_OK 8'h00
`define MGS_ERR_BAD_STATE 8'hf6
`define MGS_ERR_BAD_GROUP 8'hec
`define MGS_ERR_BAD_CMD 8'hfc
`define MGS_HEXAPOD_AXES 4'h6
`define MGS_FULL_AXES 4'h8
`define MGS_MAX_GROUPS 2'h3
`endif

// *** verif/mgs_seq_asserts.sv ***
// Port checker for the group state sequencer.
// Assumes it is bound into the sequencer and sees its ports by name.
`timescale 1ns/1ps
module mgs_seq_asserts #(parameter NGRP = 3)
(
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire cmd_valid_i,
  input wire [3:0] cmd_code_i,
  input wire [1:0] cmd_group_i,
  input wire [1:0] cfg_groups_i,
  input wire extra_groups_option_i,
  input wire [NGRP-1:0] fault_motor_i,
  input wire [NGRP-1:0] fault_travel_i,
  input wire rsp_valid_o,
  input wire [7:0] rsp_code_o,
  input wire [7:0] rsp_state_o,
  input wire [NGRP-1:0] motor_power_o,
  input wire [1:0] groups_enabled_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_answer_next: assert property (cmd_valid_i |=> rsp_valid_o)
    else $error("no answer after command");
  a_no_stray_rsp: assert property (!cmd_valid_i |=> !rsp_valid_o)
    else $error("answer without command");
  a_init_powers: assert property (rsp_valid_o && rsp_code_o == 8'h00 &&
    $past(cmd_code_i) == 4'h1 |-> rsp_state_o == 8'h2a && motor_power_o[$past(cmd_group_i)])
    else $error("init did not reach 2a with power");
  a_refuse_neg: assert property (rsp_valid_o && rsp_code_o != 8'h00 |->
    rsp_code_o[7] && rsp_state_o == 8'h00) else $error("refusal not negative");
  a_estop_off: assert property (fault_motor_i[0] [*5] |=> !motor_power_o[0])
    else $error("motor fault left power on");
  a_brake_off: assert property (fault_travel_i[0] [*5] |=> !motor_power_o[0])
    else $error("travel fault left power on");
  a_cfg_single: assert property (rsp_valid_o && $past(cmd_code_i) == 4'h8 &&
    !$past(extra_groups_option_i) && $past(cfg_groups_i) != 2'h0 |-> rsp_code_o == 8'hec)
    else $error("extra group allowed with option off");
  a_cfg_extra: assert property (rsp_valid_o && $past(cmd_code_i) == 4'h8 &&
    $past(extra_groups_option_i) && $past(cfg_groups_i) <= 2'h2 |->
    rsp_code_o == 8'h00 && groups_enabled_o == $past(cfg_groups_i)) else $error("config refused");
  a_query_range: assert property (rsp_valid_o && $past(cmd_code_i) == 4'h6 &&
    $past(cmd_group_i) > $past(groups_enabled_o) |-> rsp_code_o == 8'hec)
    else $error("query of absent group accepted");
endmodule
bind mgs_sequencer mgs_seq_asserts #(.NGRP(NGRP)) chk_u (.*);

// *** verif/mgs_stage_model.sv ***
// Stage model: raises one status pin of one group while a request is held.
// Assumes the bench holds each request as long as the pin should stand.
`timescale 1ns/1ps
module mgs_stage_model #(parameter NGRP = 3)
(
  input wire [2:0] ev_i,
  input wire [1:0] grp_i,
  output logic [NGRP-1:0] home_done_o,
  output logic [NGRP-1:0] move_done_o,
  output logic [NGRP-1:0] f_inh_o,
  output logic [NGRP-1:0] f_mot_o,
  output logic [NGRP-1:0] f_enc_o,
  output logic [NGRP-1:0] f_trav_o,
  output logic [NGRP-1:0] f_fol_o
);
  logic [NGRP-1:0] sel;
  // Released pins fall to 0, the inactive level of these status lines
  assign sel = {{(NGRP-1){1'b0}}, 1'b1} << grp_i;
  assign home_done_o = (ev_i == 3'h1) ? sel : '0;
  assign move_done_o = (ev_i == 3'h2) ? sel : '0;
  assign f_inh_o = (ev_i == 3'h3) ? sel : '0;
  assign f_mot_o = (ev_i == 3'h4) ? sel : '0;
  assign f_enc_o = (ev_i == 3'h5) ? sel : '0;
  assign f_trav_o = (ev_i == 3'h6) ? sel : '0;
  assign f_fol_o = (ev_i == 3'h7) ? sel : '0;
endmodule

// *** verif/motion_group_state_sequencer_test.sv ***
// Self-checking bench for the group state sequencer.
// Assumes a 20 MHz clock; the stage model drives every status pin.
`timescale 1ns/1ps
module motion_group_state_sequencer_test;
  logic clk = 0, rst_b = 0, cv = 0, opt = 0;
  logic [3:0] cc = 0;
  logic [1:0] cg = 0, cfg = 0;
  logic [2:0] ev = 0;
  wire [2:0] hd, md, fi, fm, fe, ft, ff, mp;
  wire rv;
  wire [7:0] rc, rs;
  wire [1:0] ge;
  int fails = 0, tests_run = 0;
  always #25 clk = ~clk;
  mgs_sequencer #(.NGRP(3), .FITTED_AXES(4'h8)) dut_u (.sys_clk_i(clk), .rst_b_i(rst_b),
    .cmd_valid_i(cv), .cmd_code_i(cc), .cmd_group_i(cg), .cfg_groups_i(cfg),
    .extra_groups_option_i(opt), .home_done_i(hd), .move_done_i(md), .fault_inhibit_i(fi),
    .fault_motor_i(fm), .fault_encoder_i(fe), .fault_travel_i(ft), .fault_follow_i(ff),
    .rsp_valid_o(rv), .rsp_code_o(rc), .rsp_state_o(rs), .motor_power_o(mp),
    .groups_enabled_o(ge));
  mgs_stage_model #(.NGRP(3)) stage_u (.ev_i(ev), .grp_i(2'h0), .home_done_o(hd),
    .move_done_o(md), .f_inh_o(fi), .f_mot_o(fm), .f_enc_o(fe), .f_trav_o(ft), .f_fol_o(ff));
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // The answer stands one cycle, so it is judged at the falling edge after it lands
  task automatic cmd(logic [3:0] c, logic [1:0] g, logic [7:0] e);
    @(negedge clk);
    cv = 1;
    cc = c;
    cg = g;
    @(negedge clk);
    cv = 0;
    chk("answer", {7'h00, rv}, 8'h01);
    chk("code", rc, e);
  endtask
  task automatic st(logic [7:0] e);
    cmd(4'h6, 2'h0, 8'h00);
    chk("state", rs, e);
  endtask
  task automatic pins(logic [2:0] e);
    ev = e;
    repeat (5) @(negedge clk);
    ev = 0;
    repeat (5) @(negedge clk);
  endtask
  task automatic t_boot;
    st(8'h00);
    cmd(4'h2, 2'h0, 8'hf6);
    st(8'h00);
  endtask
  task automatic t_ready;
    cmd(4'h1, 2'h0, 8'h00);
    chk("state", rs, 8'h2a);
    chk("power", {7'h00, mp[0]}, 8'h01);
    cmd(4'h5, 2'h0, 8'hf6);
    cmd(4'h2, 2'h0, 8'h00);
    pins(3'h1);
    st(8'h0b);
  endtask
  task automatic t_minor;
    pins(3'h7);
    st(8'h14);
    cmd(4'h5, 2'h0, 8'h00);
    cmd(4'h7, 2'h0, 8'h00);
    pins(3'h2);
    st(8'h0c);
    cmd(4'h2, 2'h0, 8'hf6);
    cmd(4'h3, 2'h0, 8'h00);
    cmd(4'h1, 2'h0, 8'h00);
  endtask
  task automatic t_homefail;
    cmd(4'h2, 2'h0, 8'h00);
    pins(3'h7);
    st(8'h03);
    cmd(4'h1, 2'h0, 8'h00);
    cmd(4'h2, 2'h0, 8'h00);
    pins(3'h6);
    st(8'h06);
  endtask
  task automatic t_major;
    for (int f = 3; f <= 6; f++)
    begin
      cmd(4'h1, 2'h0, 8'h00);
      pins(3'(f));
      st((f == 6) ? 8'h08 : 8'h07);
      chk("power", {7'h00, mp[0]}, 8'h00);
    end
  endtask
  task automatic t_groups;
    cfg = 2'h1;
    cmd(4'h8, 2'h0, 8'hec);
    cmd(4'h6, 2'h1, 8'hec);
    opt = 1;
    cfg = 2'h2;
    cmd(4'h8, 2'h0, 8'h00);
    chk("groups", {6'h00, ge}, 8'h02);
    cmd(4'h6, 2'h2, 8'h00);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    rst_b = 1;
    repeat (2) @(negedge clk);
    t_boot;
    t_ready;
    t_minor;
    t_homefail;
    t_major;
    t_groups;
    report_and_stop;
  end
endmodule
